/* File: rtl/dtec_pkg.sv */
// package: register map, control field layout and constants for the dual timer
package dtec_pkg;
  // register byte offsets on the axi4-lite bus
  localparam logic [7:0] DTEC_OFF_T0_COUNT = 8'h00;
  localparam logic [7:0] DTEC_OFF_T0_CTRL = 8'h04;
  localparam logic [7:0] DTEC_OFF_T1_LOW = 8'h08;
  localparam logic [7:0] DTEC_OFF_T1_HIGH = 8'h0C;
  localparam logic [7:0] DTEC_OFF_T1_CTRL = 8'h10;
  localparam logic [7:0] DTEC_OFF_INT_CTRL = 8'h14;
  localparam logic [7:0] DTEC_OFF_STATUS = 8'h18;
  // control register fields
  localparam int DTEC_MODE_HI = 7;
  localparam int DTEC_MODE_LO = 6;
  localparam int DTEC_SUBSEL_BIT = 5;
  localparam int DTEC_RUN_BIT = 4;
  localparam int DTEC_EDGE_BIT = 3;
  localparam int DTEC_PSC_HI = 2;
  localparam int DTEC_PSC_LO = 0;
  // interrupt control fields
  localparam int DTEC_IE0_BIT = 0;
  localparam int DTEC_IE1_BIT = 1;
  // reset values
  localparam logic [7:0] DTEC_CTRL_RST = 8'h00;
  localparam logic [7:0] DTEC_INTC_RST = 8'h00;
  localparam logic [7:0] DTEC_PRELOAD_RST = 8'h00;
  // fsys/4 divider length
  localparam int DTEC_SYS_DIV = 4;
  // axi responses
  localparam logic [1:0] DTEC_RESP_OKAY = 2'b00;
  localparam logic [1:0] DTEC_RESP_SLVERR = 2'b10;
  // operating modes, bits 7:6
  typedef enum logic [1:0] {
    DTEC_MODE_IDLE = 2'b00,
    DTEC_MODE_EVENT = 2'b01,
    DTEC_MODE_TIMER = 2'b10,
    DTEC_MODE_PULSE = 2'b11
  } dtec_mode_t;
endpackage

/* File: rtl/dtec_counter.sv */
// one count-up timer/event counter channel with preload and pulse width logic
`timescale 1ns/1ps
`default_nettype none
module dtec_counter #(
  parameter int WIDTH = 8
) (
  input wire logic aclk, // system clock
  input wire logic aresetn, // sync reset, active low
  input wire logic [1:0] mode, // operating mode bits
  input wire logic run, // run bit
  input wire logic edge_sel, // event mode: 0 rising, 1 falling
  input wire logic int_tick, // internal clock pulse
  input wire logic pin, // timer pin level
  input wire logic preload_wr, // preload write strobe
  input wire logic [WIDTH-1:0] preload_data, // preload write data
  output logic [WIDTH-1:0] count, // live counter
  output logic pulse_done, // pulse width end, one cycle
  output logic overflow // overflow pulse, one cycle
);
  import dtec_pkg::*;
  logic pin_d_r;
  logic armed_r;
  logic [WIDTH-1:0] count_r;
  logic [WIDTH-1:0] preload_r;
  logic active_edge;
  logic return_edge;
  logic rise_edge;
  logic fall_edge;
  logic inc;

  always_ff @(posedge aclk) begin
    if (!aresetn) pin_d_r <= 1'b0;
    else pin_d_r <= pin;
  end

  assign rise_edge = ~pin_d_r & pin;
  assign fall_edge = pin_d_r & ~pin;

  // pulse mode arms on the edge opposite to the event mode one
  always_comb begin
    if (mode == DTEC_MODE_PULSE) begin
      active_edge = edge_sel ? rise_edge : fall_edge;
      return_edge = edge_sel ? fall_edge : rise_edge;
    end else begin
      active_edge = edge_sel ? fall_edge : rise_edge;
      return_edge = 1'b0;
    end
    unique case (dtec_mode_t'(mode))
      DTEC_MODE_TIMER: inc = run & int_tick;
      DTEC_MODE_EVENT: inc = run & active_edge;
      DTEC_MODE_PULSE: inc = run & armed_r & int_tick;
      DTEC_MODE_IDLE: inc = 1'b0;
    endcase
  end

  // pulse width: arm on active edge, stop on return to idle level
  always_ff @(posedge aclk) begin
    if (!aresetn || !run || mode != DTEC_MODE_PULSE) armed_r <= 1'b0;
    else if (active_edge && !armed_r) armed_r <= 1'b1;
  end
  assign pulse_done = (mode == DTEC_MODE_PULSE) && run && armed_r && return_edge;

  assign overflow = inc && (count_r == {WIDTH{1'b1}});

  always_ff @(posedge aclk) begin
    if (!aresetn) preload_r <= WIDTH'(DTEC_PRELOAD_RST);
    else if (preload_wr) preload_r <= preload_data;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) count_r <= '0;
    else if (preload_wr && !run) count_r <= preload_data;
    else if (overflow) count_r <= preload_r;
    else if (inc) count_r <= count_r + 1'b1;
  end
  assign count = count_r;
endmodule
`default_nettype wire

/* File: rtl/dtec_top.sv */
// dual timer/event counter with axi4-lite register access
// Behaviour
// - one 8-bit and one 16-bit count-up counter, each with three modes.
// - 8-bit internal clock is system clock through prescaler set by bits 2:0.
// - 16-bit internal clock is sub clock or fsys/4, option plus select bit.
// - event mode counts each pin edge; bit 3 picks falling or rising.
// - count preload to all ones, then overflow request, reload, keep counting.
// - preload write while stopped also loads counter at once.
// - preload write while running reaches counter at next overflow.
// - 16-bit low byte write goes only to low byte buffer.
// - high byte write loads high byte and moves buffer to low byte.
// - high byte read latches low byte into buffer; read high first.
// - low byte read returns buffered value, not live low byte.
// - bits 7:6 pick mode; 10 is internal timer mode.
// - bit 4 is run control; clear stops counter.
// - prescaler ratio has no effect on pin-clocked counting.
// - timer mode increments exactly once per internal clock cycle.
// - overflow interrupt suppressed when its enable bit is clear.
// - mode 01 is event counting, pin bypasses prescaler.
// - mode 11 pulse width; counting starts only after active pin edge.
// - pulse width mode clears run bit when pin returns; later edges ignored.
//
// The address map and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module dtec_top #(
  parameter bit USE_SUB_CLOCK = 1'b1 // configuration option for timer 1 source
) (
  input wire logic aclk, // system clock, 250 MHz
  input wire logic aresetn, // sync reset, active low
  input wire logic [7:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [7:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  input wire logic timer0_ext_pin, // timer 0 external pin
  input wire logic timer1_ext_pin, // timer 1 external pin
  input wire logic sub_clock_tick, // sub clock, one pulse per period
  output logic timer0_irq, // timer 0 overflow request, pulse
  output logic timer1_irq // timer 1 overflow request, pulse
);
  import dtec_pkg::*;

  // ==========================================================
  // axi4-lite write channel
  logic aw_held_r;
  logic w_held_r;
  logic [7:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic bvalid_r;
  logic [1:0] bresp_r;
  logic wr_fire;
  logic wr_ok;

  assign s_axi_awready = !aw_held_r && !bvalid_r;
  assign s_axi_wready = !w_held_r && !bvalid_r;
  // address and data wait for each other; a pending response blocks both
  assign wr_fire = aw_held_r && w_held_r && !bvalid_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      awaddr_r <= 8'h00;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held_r <= 1'b1;
      awaddr_r <= s_axi_awaddr;
    end else if (wr_fire) begin
      aw_held_r <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held_r <= 1'b1;
      wdata_r <= s_axi_wdata;
      wstrb_r <= s_axi_wstrb;
    end else if (wr_fire) begin
      w_held_r <= 1'b0;
    end
  end

  always_comb begin
    unique case (awaddr_r & 8'hFC)
      DTEC_OFF_T0_COUNT, DTEC_OFF_T0_CTRL, DTEC_OFF_T1_LOW, DTEC_OFF_T1_HIGH,
      DTEC_OFF_T1_CTRL, DTEC_OFF_INT_CTRL, DTEC_OFF_STATUS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_r <= 1'b0;
      bresp_r <= DTEC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_r <= 1'b1;
      bresp_r <= wr_ok ? DTEC_RESP_OKAY : DTEC_RESP_SLVERR;
    end else if (s_axi_bready) begin
      bvalid_r <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;

  // register write strobes, byte lane 0 only
  logic wr_lane0;
  logic [7:0] wbyte;
  logic [7:0] wr_word_addr;
  logic wr_t0_count;
  logic wr_t0_ctrl;
  logic wr_t1_low;
  logic wr_t1_high;
  logic wr_t1_ctrl;
  logic wr_intc;
  assign wr_lane0 = wr_fire && wstrb_r[0];
  assign wbyte = wdata_r[7:0];
  assign wr_word_addr = awaddr_r & 8'hFC;

  always_comb begin
    wr_t0_count = 1'b0;
    wr_t0_ctrl = 1'b0;
    wr_t1_low = 1'b0;
    wr_t1_high = 1'b0;
    wr_t1_ctrl = 1'b0;
    wr_intc = 1'b0;
    if (wr_lane0) begin
      unique case (wr_word_addr)
        DTEC_OFF_T0_COUNT: wr_t0_count = 1'b1;
        DTEC_OFF_T0_CTRL: wr_t0_ctrl = 1'b1;
        DTEC_OFF_T1_LOW: wr_t1_low = 1'b1;
        DTEC_OFF_T1_HIGH: wr_t1_high = 1'b1;
        DTEC_OFF_T1_CTRL: wr_t1_ctrl = 1'b1;
        DTEC_OFF_INT_CTRL: wr_intc = 1'b1;
        default: ;
      endcase
    end
  end

  // ==========================================================
  // control registers
  logic [7:0] timer0_control_r;
  logic [7:0] timer1_control_r;
  logic [7:0] interrupt_control_0_r;
  logic t0_pulse_done;
  logic t1_pulse_done;

  always_ff @(posedge aclk) begin
    if (!aresetn) timer0_control_r <= DTEC_CTRL_RST;
    else if (wr_t0_ctrl) timer0_control_r <= wbyte;
    else if (t0_pulse_done) timer0_control_r[DTEC_RUN_BIT] <= 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) timer1_control_r <= DTEC_CTRL_RST;
    else if (wr_t1_ctrl) timer1_control_r <= wbyte;
    else if (t1_pulse_done) timer1_control_r[DTEC_RUN_BIT] <= 1'b0;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) interrupt_control_0_r <= DTEC_INTC_RST;
    else if (wr_intc) interrupt_control_0_r <= wbyte;
  end

  logic [1:0] timer0_mode_select;
  logic [1:0] timer1_mode_select;
  logic timer0_run;
  logic timer1_run;
  logic timer0_edge_select;
  logic timer1_edge_select;
  logic [2:0] timer0_prescale_ratio;
  logic timer1_clock_select;
  assign timer0_mode_select = timer0_control_r[DTEC_MODE_HI:DTEC_MODE_LO];
  assign timer1_mode_select = timer1_control_r[DTEC_MODE_HI:DTEC_MODE_LO];
  assign timer0_run = timer0_control_r[DTEC_RUN_BIT];
  assign timer1_run = timer1_control_r[DTEC_RUN_BIT];
  assign timer0_edge_select = timer0_control_r[DTEC_EDGE_BIT];
  assign timer1_edge_select = timer1_control_r[DTEC_EDGE_BIT];
  assign timer0_prescale_ratio = timer0_control_r[DTEC_PSC_HI:DTEC_PSC_LO];
  assign timer1_clock_select = timer1_control_r[DTEC_SUBSEL_BIT];
  logic timer0_irq_en;
  logic timer1_irq_en;
  assign timer0_irq_en = interrupt_control_0_r[DTEC_IE0_BIT];
  assign timer1_irq_en = interrupt_control_0_r[DTEC_IE1_BIT];

  // ==========================================================
  // clock sources
  logic [7:0] psc_r;
  logic t0_tick;
  logic [1:0] div4_r;
  logic sys4_tick;
  logic t1_tick;

  // 8-stage prescaler; ratio 2^n, n = bits 2:0 + 1
  always_ff @(posedge aclk) begin
    if (!aresetn) psc_r <= 8'h00;
    else psc_r <= psc_r + 8'h01;
  end
  // tick when the low n-1 bits are zero and bit n-1 is one
  always_comb begin
    unique case (timer0_prescale_ratio)
      3'h0: t0_tick = (psc_r[0] == 1'b1);
      3'h1: t0_tick = (psc_r[1:0] == 2'h2);
      3'h2: t0_tick = (psc_r[2:0] == 3'h4);
      3'h3: t0_tick = (psc_r[3:0] == 4'h8);
      3'h4: t0_tick = (psc_r[4:0] == 5'h10);
      3'h5: t0_tick = (psc_r[5:0] == 6'h20);
      3'h6: t0_tick = (psc_r[6:0] == 7'h40);
      3'h7: t0_tick = (psc_r[7:0] == 8'h80);
    endcase
  end

  // free-running, so the first timer 1 tick after start lands 1 to 4 cycles later
  always_ff @(posedge aclk) begin
    if (!aresetn) div4_r <= 2'b00;
    else div4_r <= div4_r + 2'b01;
  end
  assign sys4_tick = (div4_r == 2'(DTEC_SYS_DIV - 1));
  assign t1_tick = (USE_SUB_CLOCK && timer1_clock_select) ? sub_clock_tick : sys4_tick;

  // ==========================================================
  // counters
  logic [7:0] t0_count;
  logic [15:0] t1_count;
  logic t0_ovf;
  logic t1_ovf;
  logic [7:0] low_buf_r;
  logic [7:0] rd_low_buf_r;

  // prescaled tick only used by the internal-clock modes
  dtec_counter #(.WIDTH(8)) u_timer0 (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(timer0_mode_select),
    .run(timer0_run),
    .edge_sel(timer0_edge_select),
    .int_tick(t0_tick),
    .pin(timer0_ext_pin),
    .preload_wr(wr_t0_count),
    .preload_data(wbyte),
    .count(t0_count),
    .pulse_done(t0_pulse_done),
    .overflow(t0_ovf)
  );

  dtec_counter #(.WIDTH(16)) u_timer1 (
    .aclk(aclk),
    .aresetn(aresetn),
    .mode(timer1_mode_select),
    .run(timer1_run),
    .edge_sel(timer1_edge_select),
    .int_tick(t1_tick),
    .pin(timer1_ext_pin),
    .preload_wr(wr_t1_high),
    .preload_data({wbyte, low_buf_r}),
    .count(t1_count),
    .pulse_done(t1_pulse_done),
    .overflow(t1_ovf)
  );

  // ==========================================================
  // timer 1 byte buffers
  // write buffer and read latch kept apart so a read cannot spoil a pending write
  // low byte write buffer
  always_ff @(posedge aclk) begin
    if (!aresetn) low_buf_r <= 8'h00;
    else if (wr_t1_low) low_buf_r <= wbyte;
  end

  // ==========================================================
  // interrupt requests
  assign timer0_irq = t0_ovf && timer0_irq_en;
  assign timer1_irq = t1_ovf && timer1_irq_en;

  // ==========================================================
  // axi4-lite read channel
  logic rvalid_r;
  logic [31:0] rdata_r;
  logic [1:0] rresp_r;
  logic rd_fire;
  logic [7:0] rd_addr;
  assign s_axi_arready = !rvalid_r;
  assign rd_fire = s_axi_arvalid && s_axi_arready;
  assign rd_addr = s_axi_araddr & 8'hFC;

  // read-side latch for the low byte, filled by a high byte read
  always_ff @(posedge aclk) begin
    if (!aresetn) rd_low_buf_r <= 8'h00;
    else if (rd_fire && rd_addr == DTEC_OFF_T1_HIGH) rd_low_buf_r <= t1_count[7:0];
  end

  // read mux, unmapped offsets answer with an error
  logic [7:0] status_byte;
  logic [7:0] rd_byte;
  logic rd_err;
  assign status_byte = {4'h0, t1_ovf, t0_ovf, 1'b0, USE_SUB_CLOCK};

  always_comb begin
    rd_byte = 8'h00;
    rd_err = 1'b0;
    unique case (rd_addr)
      DTEC_OFF_T0_COUNT: rd_byte = t0_count;
      DTEC_OFF_T0_CTRL: rd_byte = timer0_control_r;
      DTEC_OFF_T1_LOW: rd_byte = rd_low_buf_r;
      DTEC_OFF_T1_HIGH: rd_byte = t1_count[15:8];
      DTEC_OFF_T1_CTRL: rd_byte = timer1_control_r;
      DTEC_OFF_INT_CTRL: rd_byte = interrupt_control_0_r;
      DTEC_OFF_STATUS: rd_byte = status_byte;
      default: rd_err = 1'b1;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_r <= 1'b0;
      rdata_r <= 32'h0000_0000;
      rresp_r <= DTEC_RESP_OKAY;
    end else if (rd_fire) begin
      rvalid_r <= 1'b1;
      rdata_r <= {24'h00_0000, rd_byte};
      rresp_r <= rd_err ? DTEC_RESP_SLVERR : DTEC_RESP_OKAY;
    end else if (s_axi_rready) begin
      rvalid_r <= 1'b0;
    end
  end
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rdata = rdata_r;
  assign s_axi_rresp = rresp_r;
endmodule
`default_nettype wire

/* File: tb/dtec_pin_model.sv */
// external pin and sub clock source for the dual timer bench
`timescale 1ns/1ps
`default_nettype none
module dtec_pin_model (
  input wire logic aclk, // system clock
  output logic pin0, // timer 0 pin level
  output logic pin1, // timer 1 pin level
  output logic sub_tick // sub clock pulse
);
  initial begin
    pin0 = 1'b0;
    pin1 = 1'b0;
    sub_tick = 1'b0;
  end
  task set0(input logic v);
    @(posedge aclk);
    pin0 <= v;
  endtask
  task set1(input logic v);
    @(posedge aclk);
    pin1 <= v;
  endtask
  task pulse0(input int w);
    set0(1'b1);
    repeat (w) @(posedge aclk);
    pin0 <= 1'b0;
    repeat (3) @(posedge aclk);
  endtask
  // sparse ticks, one cycle high each
  task tick(input int n);
    repeat (n) begin
      @(posedge aclk);
      sub_tick <= 1'b1;
      @(posedge aclk);
      sub_tick <= 1'b0;
      repeat (2) @(posedge aclk);
    end
  endtask
endmodule
`default_nettype wire

/* File: tb/dtec_checker.sv */
// port assertions for the dual timer
`timescale 1ns/1ps
`default_nettype none
module dtec_checker (
  input wire logic aclk, // clock
  input wire logic aresetn, // reset
  input wire logic s_axi_awvalid, // aw valid
  input wire logic s_axi_awready, // aw ready
  input wire logic s_axi_wvalid, // w valid
  input wire logic s_axi_wready, // w ready
  input wire logic [1:0] s_axi_bresp, // b resp
  input wire logic s_axi_bvalid, // b valid
  input wire logic s_axi_bready, // b ready
  input wire logic s_axi_arvalid, // ar valid
  input wire logic s_axi_arready, // ar ready
  input wire logic [31:0] s_axi_rdata, // r data
  input wire logic s_axi_rvalid, // r valid
  input wire logic s_axi_rready, // r ready
  input wire logic timer0_irq, // irq 0
  input wire logic timer1_irq // irq 1
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // ========================================
  // checks
  property p_irq0; timer0_irq |=> !timer0_irq; endproperty
  a_irq0: assert property (p_irq0) else $error("irq0 too long");
  property p_irq1; timer1_irq |=> !timer1_irq; endproperty
  a_irq1: assert property (p_irq1) else $error("irq1 too long");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp); endproperty
  a_bhold: assert property (p_bhold) else $error("bresp dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata); endproperty
  a_rhold: assert property (p_rhold) else $error("rdata dropped");
  property p_rans; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
  a_rans: assert property (p_rans) else $error("read late");
  property p_rblk; s_axi_rvalid |-> !s_axi_arready; endproperty
  a_rblk: assert property (p_rblk) else $error("ar taken early");
  property p_bans; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:3] s_axi_bvalid; endproperty
  a_bans: assert property (p_bans) else $error("write late");
  property p_bblk; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
  a_bblk: assert property (p_bblk) else $error("aw taken early");
endmodule
bind dtec_top dtec_checker u_chk (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
  .s_axi_rready, .timer0_irq, .timer1_irq);
`default_nettype wire

/* File: tb/dtec_top_tb.sv */
// self-checking bench for the dual timer
`timescale 1ns/1ps
`default_nettype none
module dtec_top_tb;
  import dtec_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, timer0_irq, timer1_irq;
  logic pin0, pin1, sub_tick;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr;
  logic [31:0] s_axi_rdata, rv, c;
  int n_fail = 0, cmp_count = 0, cyc = 0, last0 = 0, gap0 = 0, n0 = 0, n1 = 0, m;
  always #2 aclk = ~aclk;
  dtec_top uut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
    .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer0_ext_pin(pin0),
    .timer1_ext_pin(pin1), .sub_clock_tick(sub_tick), .timer0_irq, .timer1_irq);
  dtec_pin_model u_src (.aclk, .pin0, .pin1, .sub_tick);
  // irq pulse counting and spacing
  always @(negedge aclk) begin
    cyc++;
    if (timer0_irq === 1'b1) begin
      gap0 = cyc - last0;
      last0 = cyc;
      n0++;
    end
    if (timer1_irq === 1'b1) n1++;
  end
  // ========================================
  // bus tasks
  task chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    logic ta, tw;
    ta = 1'b0;
    tw = 1'b0;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (!(ta && tw)) begin
      @(negedge aclk);
      ta = ta | s_axi_awready;
      tw = tw | s_axi_wready;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
    do @(negedge aclk); while (s_axi_bvalid !== 1'b1);
    @(posedge aclk);
    s_axi_bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(negedge aclk); while (s_axi_arready !== 1'b1);
    @(posedge aclk);
    s_axi_arvalid <= 1'b0;
    do @(negedge aclk); while (s_axi_rvalid !== 1'b1);
    rv = s_axi_rdata;
    rr = s_axi_rresp;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    rd(a);
    chk(rv, e);
  endtask
  task w0(input int k);
    repeat (k) begin
      m = n0;
      wait (n0 != m);
    end
  endtask
  // ========================================
  // scenarios
  task t_reset;
    rdc(DTEC_OFF_T0_CTRL, 32'(DTEC_CTRL_RST));
    rdc(DTEC_OFF_T1_CTRL, 32'(DTEC_CTRL_RST));
    rdc(DTEC_OFF_INT_CTRL, 32'(DTEC_INTC_RST));
    rd(8'h1C);
    chk(32'(rr), 32'(DTEC_RESP_SLVERR));
    @(posedge aclk);
    s_axi_wstrb <= 4'h0;
    wr(DTEC_OFF_T0_CTRL, 32'h0000_00FF);
    s_axi_wstrb <= 4'hf;
    rdc(DTEC_OFF_T0_CTRL, 32'(DTEC_CTRL_RST));
  endtask
  task t_timer0;
    wr(DTEC_OFF_T0_CTRL, 8'h80);
    wr(DTEC_OFF_T0_COUNT, 8'hFD);
    rdc(DTEC_OFF_T0_COUNT, 8'hFD);
    wr(DTEC_OFF_INT_CTRL, 8'h01);
    for (int n = 0; n < 3; n++) begin
      wr(DTEC_OFF_T0_CTRL, 32'h90 | n);
      w0(2);
      chk(gap0, 3 << (n + 1));
    end
    wr(DTEC_OFF_T0_COUNT, 8'hF0);
    w0(2);
    chk(gap0, 128);
    wr(DTEC_OFF_INT_CTRL, 8'h00);
    m = n0;
    repeat (300) @(posedge aclk);
    chk(n0, m);
    wr(DTEC_OFF_T0_CTRL, 8'h80);
    rd(DTEC_OFF_T0_COUNT);
    c = rv;
    repeat (20) @(posedge aclk);
    rdc(DTEC_OFF_T0_COUNT, c);
  endtask
  task t_event;
    for (int e = 0; e < 2; e++) begin
      wr(DTEC_OFF_T0_CTRL, 32'h40 | e << 3);
      wr(DTEC_OFF_T0_COUNT, 8'h00);
      wr(DTEC_OFF_T0_CTRL, 32'h57 | e << 3);
      u_src.set0(1'b1);
      repeat (3) @(posedge aclk);
      rdc(DTEC_OFF_T0_COUNT, 1 - e);
      u_src.set0(1'b0);
      repeat (3) @(posedge aclk);
      rdc(DTEC_OFF_T0_COUNT, 1);
    end
  endtask
  task t_pulse;
    wr(DTEC_OFF_T0_CTRL, 8'hC8);
    wr(DTEC_OFF_T0_COUNT, 8'h00);
    wr(DTEC_OFF_T0_CTRL, 8'hD8);
    repeat (10) @(posedge aclk);
    rdc(DTEC_OFF_T0_COUNT, 0);
    u_src.pulse0(20);
    rd(DTEC_OFF_T0_COUNT);
    c = rv;
    chk(32'(c >= 9 && c <= 11), 1);
    rdc(DTEC_OFF_T0_CTRL, 8'hC8);
    u_src.pulse0(20);
    rdc(DTEC_OFF_T0_COUNT, c);
  endtask
  task t_timer1;
    wr(DTEC_OFF_T1_LOW, 8'h34);
    rdc(DTEC_OFF_T1_HIGH, 0);
    rdc(DTEC_OFF_T1_LOW, 0);
    wr(DTEC_OFF_T1_HIGH, 8'h12);
    rdc(DTEC_OFF_T1_HIGH, 8'h12);
    rdc(DTEC_OFF_T1_LOW, 8'h34);
    wr(DTEC_OFF_T1_CTRL, 8'hB0);
    u_src.tick(5);
    rdc(DTEC_OFF_T1_HIGH, 8'h12);
    u_src.tick(3);
    rdc(DTEC_OFF_T1_LOW, 8'h39);
    wr(DTEC_OFF_T1_CTRL, 8'h80);
    rdc(DTEC_OFF_T1_HIGH, 8'h12);
    rdc(DTEC_OFF_T1_LOW, 8'h3C);
    wr(DTEC_OFF_T1_CTRL, 8'h90);
    repeat (40) @(posedge aclk);
    wr(DTEC_OFF_T1_CTRL, 8'h80);
    rd(DTEC_OFF_T1_HIGH);
    rd(DTEC_OFF_T1_LOW);
    chk(32'(rv >= 8'h45 && rv <= 8'h49), 1);
    wr(DTEC_OFF_INT_CTRL, 8'h02);
    wr(DTEC_OFF_T1_LOW, 8'hFF);
    wr(DTEC_OFF_T1_HIGH, 8'hFF);
    wr(DTEC_OFF_T1_CTRL, 8'hB0);
    m = n1;
    u_src.tick(1);
    repeat (2) @(posedge aclk);
    chk(n1, m + 1);
    rdc(DTEC_OFF_T1_HIGH, 8'hFF);
    wr(DTEC_OFF_T1_CTRL, 8'h48);
    wr(DTEC_OFF_T1_LOW, 8'h00);
    wr(DTEC_OFF_T1_HIGH, 8'h00);
    wr(DTEC_OFF_T1_CTRL, 8'h58);
    u_src.set1(1'b1);
    repeat (3) @(posedge aclk);
    u_src.set1(1'b0);
    repeat (3) @(posedge aclk);
    rdc(DTEC_OFF_T1_HIGH, 0);
    rdc(DTEC_OFF_T1_LOW, 1);
  endtask
  task results;
    $display("comparisons=%0d mismatches=%0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    #100000;
    n_fail++;
    results;
  end
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset;
    t_timer0;
    t_event;
    t_pulse;
    t_timer1;
    results;
  end
endmodule
`default_nettype wire
